//--- verilog/difn_pkg.sv
// Constants and carrier types shared by the input function trigger block.
// Assumes a single 10 MHz clock and a Wishbone classic slave with 32-bit data.
package difn_pkg;

  // Function codes handled by this block, and their span.
  localparam int FN_LO         = 25;
  localparam int FN_HI         = 75;
  localparam int FN_NUM        = FN_HI - FN_LO + 1;
  localparam int FN_MSP        = 27;
  localparam int FN_FIX_CANCEL = 39;
  localparam int FN_FIX_TRIG   = 40;
  localparam int FN_FWD_LIM    = 43;
  localparam int FN_REV_LIM    = 44;
  localparam int FN_RELOAD     = 46;
  localparam int FN_GEAR2      = 56;
  localparam int FN_OVERHEAT   = 57;
  localparam int FN_ESTOP      = 58;
  localparam int FN_FF_CLR     = 59;
  localparam int FN_FF_SET     = 60;
  localparam int FN_CNT_PULSE  = 61;
  localparam int FN_CNT_CLR    = 62;
  localparam int FN_UP         = 63;
  localparam int FN_DOWN       = 64;
  localparam int FN_HOLD       = 65;
  localparam int FN_ZERO_DRIFT = 67;
  localparam int FN_JOG_FWD    = 69;
  localparam int FN_JOG_REV    = 70;
  localparam int FN_REWIND     = 71;
  localparam int FN_CUR_CAL    = 72;
  localparam int FN_PHASE      = 73;
  localparam int FN_ABS_ZERO   = 74;
  localparam int FN_STO        = 75;

  // Width of one input_function_select field and of the monitor's upper word.
  localparam int SEL_W   = 7;
  localparam int MON1_W  = FN_NUM - 32;
  localparam int IRQ_W   = 8;
  localparam int CTRL_W  = 2;

  // Register byte offsets.
  localparam logic [7:0] OFS_SEL_BASE = 8'h00;
  localparam logic [7:0] OFS_MON0     = 8'h40;
  localparam logic [7:0] OFS_MON1     = 8'h44;
  localparam logic [7:0] OFS_COUNT    = 8'h48;
  localparam logic [7:0] OFS_FLAG     = 8'h4C;
  localparam logic [7:0] OFS_CTRL     = 8'h50;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h54;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h58;

  // Control bits.
  localparam int CTRL_SPEED_STEP = 0;
  localparam int CTRL_POS_MODE   = 1;

  // Interrupt status bits.
  localparam int IRQ_ESTOP    = 0;
  localparam int IRQ_OVERHEAT = 1;
  localparam int IRQ_FIX_TRIG = 2;
  localparam int IRQ_MSP_GO   = 3;
  localparam int IRQ_MSP_STOP = 4;
  localparam int IRQ_ZERO_DRF = 5;
  localparam int IRQ_RELOAD   = 6;
  localparam int IRQ_CNT_WRAP = 7;

  // Reset values.
  localparam logic [SEL_W-1:0]  SEL_RST  = 7'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
  localparam logic [IRQ_W-1:0]  MASK_RST = 8'h00;

  // Commands that stay asserted while their input is high.
  typedef struct packed {
    logic fwd_limit;
    logic rev_limit;
    logic fixlen_cancel;
    logic estop;
    logic overheat;
    logic gear2_sel;
    logic rewind_ctl;
    logic speed_up;
    logic speed_down;
    logic speed_hold;
    logic safe_torque_off;
  } level_cmd_t;

  // Commands that last one clock per qualifying transition.
  typedef struct packed {
    logic msp_start;
    logic msp_stop;
    logic fixlen_trigger;
    logic logic_reload;
    logic zero_drift_start;
    logic current_cal;
    logic phase_learn;
    logic abs_zero;
    logic jog_fwd;
    logic jog_rev;
  } pulse_cmd_t;

endpackage : difn_pkg

//--- verilog/din_sync.sv
// Three-stage synchroniser with agreement qualification for the input pins.
// Assumes the pins are asynchronous to clk_i.
`timescale 1ns/100ps
module din_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] eff_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] eff;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // The first stage feeds only the second; a bit rises once stages two and three agree high and falls as soon as they differ.
  always_comb begin
    s_nxt     = s_r;
    s_nxt.s1  = pin_i;
    s_nxt.s2  = s_r.s1;
    s_nxt.s3  = s_r.s2;
    s_nxt.eff = (s_r.s2 & s_r.s3) | (s_r.eff & ~(s_r.s2 ^ s_r.s3));
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign eff_o = s_r.eff;

endmodule : din_sync

//--- verilog/fn_edge.sv
// Rise and fall detector over a vector of function levels.
// Assumes the levels are already in the clk_i domain.
`timescale 1ns/100ps
module fn_edge #(
  parameter int W = 51
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] lvl_i,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  typedef struct packed {
    logic [W-1:0] prev;
  } edge_state_t;

  edge_state_t s_r;
  edge_state_t s_nxt;

  // The previous sample is kept so that each transition yields one pulse.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = lvl_i;
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // One clock per transition, since prev catches up on the next edge.
  assign rise_o = lvl_i & ~s_r.prev;
  assign fall_o = ~lvl_i & s_r.prev;

endmodule : fn_edge

//--- verilog/din_func_trigger.sv
// Digital input function trigger: maps qualified input pins to drive commands.
// Assumes a Wishbone classic master, pins asynchronous to clk_i, one clock.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module din_func_trigger #(
  parameter int NUM_IN = 8,
  parameter int CNT_W  = 16
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [NUM_IN-1:0]    din_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      irq_o,
  output difn_pkg::level_cmd_t      level_cmd_o,
  output difn_pkg::pulse_cmd_t      pulse_cmd_o,
  output logic                      flag_o,
  output logic      [CNT_W-1:0]     count_o
);

  localparam int FN_NUM = difn_pkg::FN_NUM;
  localparam int SEL_W  = difn_pkg::SEL_W;

  typedef struct packed {
    logic [NUM_IN-1:0][SEL_W-1:0]     sel;
    logic [difn_pkg::CTRL_W-1:0]      ctrl;
    logic [difn_pkg::IRQ_W-1:0]       irq_stat;
    logic [difn_pkg::IRQ_W-1:0]       irq_mask;
    logic                             flag;
    logic [CNT_W-1:0]                 cnt;
    difn_pkg::level_cmd_t             lvl;
    difn_pkg::pulse_cmd_t             pls;
    logic                             ack;
    logic [31:0]                      dat;
    logic                             irq;
  } trig_state_t;

  trig_state_t                s_r;
  trig_state_t                s_nxt;
  logic [NUM_IN-1:0]          eff;
  logic [FN_NUM-1:0]          fn_lvl;
  logic [FN_NUM-1:0]          fn_rise;
  logic [FN_NUM-1:0]          fn_fall;

  // Bit of a function vector picked by its function code.
  function automatic logic bit_of(input logic [FN_NUM-1:0] v, input int code);
    return v[code - difn_pkg::FN_LO];
  endfunction : bit_of

  // Expands Wishbone byte selects into a bit mask.
  function automatic logic [31:0] wmask(input logic [3:0] bsel);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{bsel[b]}};
    end
    return m;
  endfunction : wmask

  // Function level: high when any input selecting the code is effective high.
  // Two inputs may share one code; they are ORed together.
  function automatic logic [FN_NUM-1:0] decode(
    input logic [NUM_IN-1:0]            e,
    input logic [NUM_IN-1:0][SEL_W-1:0] sl
  );
    logic [FN_NUM-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      for (int c = difn_pkg::FN_LO; c <= difn_pkg::FN_HI; c++) begin
        if (sl[i] == SEL_W'(c)) begin
          v[c - difn_pkg::FN_LO] = v[c - difn_pkg::FN_LO] | e[i];
        end
      end
    end
    return v;
  endfunction : decode

  // Pin qualification; pins outside this clock pass three stages.
  din_sync #(
    .W (NUM_IN)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (din_i),
    .eff_o (eff)
  );

  // Effective state of every handled function code.
  assign fn_lvl = decode(eff, s_r.sel);

  // Transition detection against the previous sample.
  fn_edge #(
    .W (FN_NUM)
  ) u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .lvl_i  (fn_lvl),
    .rise_o (fn_rise),
    .fall_o (fn_fall)
  );

  // Next-state logic for commands, internal flag, counter, interrupts and bus.
  always_comb begin
    logic [31:0]               rd;
    logic [31:0]               wm;
    logic [5:0]                idx;
    logic [difn_pkg::IRQ_W-1:0] ev;
    logic [difn_pkg::IRQ_W-1:0] clr;
    logic                      wr;
    rd    = 32'h0000_0000;
    wm    = wmask(wb_sel_i);
    idx   = wb_adr_i[7:2];
    ev    = '0;
    clr   = '0;
    wr    = 1'b0;
    s_nxt = s_r;

    // Level commands follow the decoded state with one register stage.
    s_nxt.lvl.fwd_limit       = s_r.ctrl[difn_pkg::CTRL_POS_MODE]
                                & bit_of(fn_lvl, difn_pkg::FN_FWD_LIM);
    s_nxt.lvl.rev_limit       = s_r.ctrl[difn_pkg::CTRL_POS_MODE]
                                & bit_of(fn_lvl, difn_pkg::FN_REV_LIM);
    s_nxt.lvl.fixlen_cancel   = bit_of(fn_lvl, difn_pkg::FN_FIX_CANCEL);
    s_nxt.lvl.estop           = bit_of(fn_lvl, difn_pkg::FN_ESTOP);
    s_nxt.lvl.overheat        = bit_of(fn_lvl, difn_pkg::FN_OVERHEAT);
    s_nxt.lvl.gear2_sel       = bit_of(fn_lvl, difn_pkg::FN_GEAR2);
    s_nxt.lvl.rewind_ctl      = bit_of(fn_lvl, difn_pkg::FN_REWIND);
    s_nxt.lvl.speed_up        = s_r.ctrl[difn_pkg::CTRL_SPEED_STEP]
                                & bit_of(fn_lvl, difn_pkg::FN_UP);
    s_nxt.lvl.speed_down      = s_r.ctrl[difn_pkg::CTRL_SPEED_STEP]
                                & bit_of(fn_lvl, difn_pkg::FN_DOWN);
    s_nxt.lvl.speed_hold      = s_r.ctrl[difn_pkg::CTRL_SPEED_STEP]
                                & bit_of(fn_lvl, difn_pkg::FN_HOLD);
    s_nxt.lvl.safe_torque_off = bit_of(fn_lvl, difn_pkg::FN_STO);

    // Pulse commands last one clock per qualifying transition.
    s_nxt.pls.msp_start        = bit_of(fn_rise, difn_pkg::FN_MSP);
    s_nxt.pls.msp_stop         = bit_of(fn_fall, difn_pkg::FN_MSP);
    s_nxt.pls.fixlen_trigger   = bit_of(fn_rise, difn_pkg::FN_FIX_TRIG);
    s_nxt.pls.logic_reload     = bit_of(fn_rise, difn_pkg::FN_RELOAD);
    s_nxt.pls.zero_drift_start = bit_of(fn_fall, difn_pkg::FN_ZERO_DRIFT);
    s_nxt.pls.current_cal      = bit_of(fn_rise, difn_pkg::FN_CUR_CAL);
    s_nxt.pls.phase_learn      = bit_of(fn_rise, difn_pkg::FN_PHASE);
    s_nxt.pls.abs_zero         = bit_of(fn_rise, difn_pkg::FN_ABS_ZERO);
    s_nxt.pls.jog_fwd          = bit_of(fn_rise, difn_pkg::FN_JOG_FWD);
    s_nxt.pls.jog_rev          = bit_of(fn_rise, difn_pkg::FN_JOG_REV);

    // Internal flip-flop; clear is checked first when both edges coincide.
    if (bit_of(fn_rise, difn_pkg::FN_FF_CLR)) begin
      s_nxt.flag = 1'b0;
    end else if (bit_of(fn_rise, difn_pkg::FN_FF_SET)) begin
      s_nxt.flag = 1'b1;
    end

    // Internal counter; a held clear overrides any pulse in the same clock.
    if (bit_of(fn_lvl, difn_pkg::FN_CNT_CLR)) begin
      s_nxt.cnt = '0;
    end else if (bit_of(fn_rise, difn_pkg::FN_CNT_PULSE)) begin
      s_nxt.cnt = s_r.cnt + CNT_W'(1);
      ev[difn_pkg::IRQ_CNT_WRAP] = &s_r.cnt;
    end

    // Interrupt events are taken from the pulse and rising-edge sources.
    ev[difn_pkg::IRQ_ESTOP]    = bit_of(fn_rise, difn_pkg::FN_ESTOP);
    ev[difn_pkg::IRQ_OVERHEAT] = bit_of(fn_rise, difn_pkg::FN_OVERHEAT);
    ev[difn_pkg::IRQ_FIX_TRIG] = s_nxt.pls.fixlen_trigger;
    ev[difn_pkg::IRQ_MSP_GO]   = s_nxt.pls.msp_start;
    ev[difn_pkg::IRQ_MSP_STOP] = s_nxt.pls.msp_stop;
    ev[difn_pkg::IRQ_ZERO_DRF] = s_nxt.pls.zero_drift_start;
    ev[difn_pkg::IRQ_RELOAD]   = s_nxt.pls.logic_reload;

    // Read multiplexer; unmapped addresses read zero but are still acknowledged.
    case (wb_adr_i)
      difn_pkg::OFS_MON0: begin
        rd = fn_lvl[31:0];
      end
      difn_pkg::OFS_MON1: begin
        rd = {{(32 - difn_pkg::MON1_W){1'b0}}, fn_lvl[FN_NUM-1:32]};
      end
      difn_pkg::OFS_COUNT: begin
        rd = 32'(s_r.cnt);
      end
      difn_pkg::OFS_FLAG: begin
        rd = {31'h0000_0000, s_r.flag};
      end
      difn_pkg::OFS_CTRL: begin
        rd = 32'(s_r.ctrl);
      end
      difn_pkg::OFS_IRQ_STAT: begin
        rd = 32'(s_r.irq_stat);
      end
      difn_pkg::OFS_IRQ_MASK: begin
        rd = 32'(s_r.irq_mask);
      end
      default: begin
        if (wb_adr_i < difn_pkg::OFS_MON0 && 32'(idx) < NUM_IN) begin
          rd = 32'(s_r.sel[idx]);
        end
      end
    endcase

    // One-wait-state slave: ack rises the clock after the request and drops next.
    s_nxt.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = rd;
      wr        = wb_we_i;
    end

    // Register writes honour the byte lanes.
    if (wr) begin
      case (wb_adr_i)
        difn_pkg::OFS_CTRL: begin
          s_nxt.ctrl = (s_r.ctrl & ~wm[difn_pkg::CTRL_W-1:0])
                       | (wb_dat_i[difn_pkg::CTRL_W-1:0] & wm[difn_pkg::CTRL_W-1:0]);
        end
        difn_pkg::OFS_IRQ_STAT: begin
          clr = wb_dat_i[difn_pkg::IRQ_W-1:0] & wm[difn_pkg::IRQ_W-1:0];
        end
        difn_pkg::OFS_IRQ_MASK: begin
          s_nxt.irq_mask = (s_r.irq_mask & ~wm[difn_pkg::IRQ_W-1:0])
                           | (wb_dat_i[difn_pkg::IRQ_W-1:0] & wm[difn_pkg::IRQ_W-1:0]);
        end
        default: begin
          if (wb_adr_i < difn_pkg::OFS_MON0 && 32'(idx) < NUM_IN && wb_sel_i[0]) begin
            s_nxt.sel[idx] = wb_dat_i[SEL_W-1:0];
          end
        end
      endcase
    end

    // Sticky status: a new event beats a write-one-to-clear in the same clock.
    s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
    s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.sel      <= {NUM_IN{difn_pkg::SEL_RST}};
      s_r.ctrl     <= difn_pkg::CTRL_RST;
      s_r.irq_mask <= difn_pkg::MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output is a field of the state register.
  assign wb_dat_o    = s_r.dat;
  assign wb_ack_o    = s_r.ack;
  assign irq_o       = s_r.irq;
  assign level_cmd_o = s_r.lvl;
  assign pulse_cmd_o = s_r.pls;
  assign flag_o      = s_r.flag;
  assign count_o     = s_r.cnt;

endmodule : din_func_trigger

//--- verification/din_switch_bank.sv
// Model of the external contacts that drive the input pins.
// Assumes the bench asks for contact levels on lvl_i at a rising edge.
`timescale 1ns/100ps
module din_switch_bank #(
  parameter int N = 8
) (
  input  wire logic         clk_i,
  input  wire logic [N-1:0] lvl_i,
  output logic      [N-1:0] din_o
);
  // Contacts settle one clock late, so the pins never move on the sampling edge.
  always_ff @(posedge clk_i) begin
    din_o <= lvl_i;
  end
endmodule : din_switch_bank

//--- verification/din_func_trigger_checker.sv
// Concurrent checks on the ports of the input function trigger.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module din_func_trigger_checker #(
  parameter int CNT_W = 16
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire difn_pkg::pulse_cmd_t pulse_cmd_o,
  input wire difn_pkg::level_cmd_t level_cmd_o,
  input wire logic                 flag_o,
  input wire logic [CNT_W-1:0]     count_o
);
  // All checks share the one clock domain.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered after one wait state");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  AST_RST_CLR: assert property ($fell(rst_i) |-> pulse_cmd_o == '0 &&
      level_cmd_o == '0 && !flag_o && count_o == '0)
    else $error("outputs not cleared by reset");
  AST_MSP_ONE: assert property (pulse_cmd_o.msp_start |=> !pulse_cmd_o.msp_start)
    else $error("sequence start pulse too long");
  AST_MSP_EXCL: assert property (pulse_cmd_o.msp_start |->
      !pulse_cmd_o.msp_stop ##1 !pulse_cmd_o.msp_stop)
    else $error("sequence stop too close to start");
  AST_ZERO_ONE: assert property (pulse_cmd_o.zero_drift_start |=>
      !pulse_cmd_o.zero_drift_start [*2])
    else $error("zero drift pulse repeated");
  AST_FIX_ONE: assert property (pulse_cmd_o.fixlen_trigger |=> !pulse_cmd_o.fixlen_trigger)
    else $error("fixed length trigger pulse too long");
  AST_REL_ONE: assert property (pulse_cmd_o.logic_reload |=> !pulse_cmd_o.logic_reload)
    else $error("reload pulse too long");
  AST_CNT_STEP: assert property (count_o != $past(count_o) |->
      count_o == '0 || count_o == $past(count_o) + 1'b1)
    else $error("counter moved by more than one");
endmodule : din_func_trigger_checker

bind din_func_trigger din_func_trigger_checker #(.CNT_W(CNT_W)) chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pulse_cmd_o(pulse_cmd_o), .level_cmd_o(level_cmd_o),
  .flag_o(flag_o), .count_o(count_o));

//--- verification/din_func_trigger_tb.sv
// Self-checking bench for the input function trigger.
// Assumes the switch bank model and the checker bound to the design.
`timescale 1ns/100ps
module din_func_trigger_tb;
  localparam logic [7:0] RA [8] = '{8'h00, 8'h1C, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'hFC};
  localparam int         CD [8] = '{27, 67, 59, 60, 61, 62, 40, 58};
  localparam int         EC [6] = '{46, 72, 73, 74, 69, 70};
  localparam logic [9:0] EV [6] = '{10'h040, 10'h010, 10'h008, 10'h004, 10'h002, 10'h001};
  localparam int         LC [10] = '{57, 56, 71, 39, 75, 63, 64, 65, 43, 44};
  localparam logic [10:0] LV [10] = '{11'h040, 11'h020, 11'h010, 11'h100, 11'h001,
                                      11'h008, 11'h004, 11'h002, 11'h400, 11'h200};
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 cyc   = 1'b0;
  logic                 stb   = 1'b0;
  logic                 we    = 1'b0;
  logic [7:0]           adr   = 8'h00;
  logic [31:0]          wdat  = 32'h0;
  logic [7:0]           lvl   = 8'h00;
  logic [3:0]           bsel  = 4'hF;
  logic [31:0]          seed  = 32'h2F;
  logic [7:0]           din_i;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic                 irq_o;
  logic                 flag_o;
  logic [15:0]          count_o;
  difn_pkg::level_cmd_t level_cmd_o;
  difn_pkg::pulse_cmd_t pulse_cmd_o;
  logic [31:0]          rq [$];
  logic [9:0]           pq [$];
  int                   err_total = 0;
  int                   n_tests = 0;

  // Default widths are used: eight pins and a sixteen-bit counter.
  din_switch_bank din_switch_bank_inst (.clk_i(clk_i), .lvl_i(lvl), .din_o(din_i));
  din_func_trigger din_func_trigger_inst (
    .clk_i(clk_i), .rst_i(rst_i), .din_i(din_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .level_cmd_o(level_cmd_o),
    .pulse_cmd_o(pulse_cmd_o), .flag_o(flag_o), .count_o(count_o));

  // Free-running 10 MHz clock.
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle; the request is held until ack is seen, with no fixed latency assumed.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic pin(input int i, input logic v);
    @(posedge clk_i);
    lvl[i] <= v;
    repeat (8) @(posedge clk_i);
  endtask : pin

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // Each answer takes the oldest note; a pulse nobody announced meets an impossible note.
  always @(posedge clk_i) begin
    if (rst_i === 1'b0 && wb_ack_o === 1'b1 && !we) begin
      chk("read", rq.size() > 0 ? rq.pop_front() : 32'hFFFFFFFF, wb_dat_o);
    end
    if (rst_i === 1'b0 && pulse_cmd_o !== 10'h000) begin
      chk("pulse", pq.size() > 0 ? {22'h0, pq.pop_front()} : 32'hFFFFFFFF, pulse_cmd_o);
    end
  end

  // Watchdog sized well above the fewer than one thousand cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end

  initial begin
    int n;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (RA[k]) rd(RA[k], 32'h0);
    bus(1'b1, 8'h48, 32'hFFFF);
    rd(8'h48, 32'h0);
    foreach (CD[k]) bus(1'b1, 8'(4 * k), 32'(CD[k]));
    rd(8'h00, 32'h1B);
    pq.push_back(10'h200); pin(0, 1'b1);
    pq.push_back(10'h100); pin(0, 1'b0);
    pin(1, 1'b1);
    pq.push_back(10'h020); pin(1, 1'b0);
    pq.push_back(10'h080); pin(6, 1'b1); pin(6, 1'b0);
    foreach (EC[k]) begin
      bus(1'b1, 8'h18, 32'(EC[k]));
      pq.push_back(EV[k]); pin(6, 1'b1); pin(6, 1'b0);
    end
    pin(3, 1'b1); rd(8'h4C, 32'h1); chk("flag", 32'h1, flag_o);
    pin(3, 1'b0); pin(2, 1'b1); rd(8'h4C, 32'h0); pin(2, 1'b0);
    n = int'(rnd() % 32'h5) + 1;
    repeat (n) begin
      pin(4, 1'b1); pin(4, 1'b0);
    end
    rd(8'h48, 32'(n)); chk("count", 32'(n), count_o);
    pin(5, 1'b1); pin(4, 1'b1); pin(4, 1'b0); rd(8'h48, 32'h0); pin(5, 1'b0);
    pin(7, 1'b1); chk("estop", 32'h080, level_cmd_o);
    rd(8'h44, 32'h2); rd(8'h54, 32'h7D); chk("irq", 32'h0, irq_o);
    bus(1'b1, 8'h58, 32'h1); repeat (2) @(posedge clk_i); chk("irq", 32'h1, irq_o);
    bus(1'b1, 8'h54, 32'h1); repeat (2) @(posedge clk_i); chk("irq", 32'h0, irq_o);
    pin(7, 1'b0); chk("estop", 32'h0, level_cmd_o);
    bus(1'b1, 8'h1C, 32'h3F);
    pin(7, 1'b1); chk("gated", 32'h0, level_cmd_o); pin(7, 1'b0);
    bus(1'b1, 8'h50, 32'h3);
    foreach (LC[k]) begin
      bus(1'b1, 8'h1C, 32'(LC[k]));
      pin(7, 1'b1); chk("level", 32'(LV[k]), level_cmd_o);
      pin(7, 1'b0); chk("level", 32'h0, level_cmd_o);
    end
    // A select write without the low byte lane must leave the field alone.
    @(posedge clk_i);
    bsel <= 4'hE;
    bus(1'b1, 8'h00, 32'h05);
    bsel <= 4'hF;
    rd(8'h00, 32'h1B);
    chk("pulses left", 32'h0, pq.size());
    print_verdict();
  end
endmodule : din_func_trigger_tb
